/* File: sfg_pkg.sv */
package sfg_pkg;
	localparam int          CLK_MHZ           = 200;
	localparam int          STARTUP_DELAY_MS  = 3;
	localparam int          STARTUP_CYCLES    = STARTUP_DELAY_MS * 1000 * CLK_MHZ;
	localparam int          SEL_DELAY_US      = 70;
	localparam int          SEL_CYCLES        = SEL_DELAY_US * CLK_MHZ;
	localparam logic [7:0]  OP_MAIN_READ      = 8'hd2;
	localparam logic [7:0]  OP_BUF1_READ      = 8'hd4;
	localparam logic [7:0]  OP_BUF2_READ      = 8'hd6;
	localparam logic [2:0]  DUMMY_MAIN        = 3'h4;
	localparam logic [2:0]  DUMMY_BUF         = 3'h1;
	localparam int          PAGE_MSB          = 20;
	localparam int          PAGE_LSB          = 9;
	localparam int          BYTE_MSB          = 8;
	localparam logic [11:0] PAGE_RST          = 12'h000;
	localparam logic [8:0]  BYTE_RST          = 9'h000;

	typedef enum logic [2:0] {
		SFG_IDLE   = 3'h0,
		SFG_OPCODE = 3'h1,
		SFG_ADDR   = 3'h3,
		SFG_DUMMY  = 3'h2,
		SFG_DONE   = 3'h6
	} sfg_state_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  opcode;
		logic [11:0] page;
		logic        page_used;
		logic [8:0]  byte_addr;
		logic        byte_used;
		logic [2:0]  dummy;
		logic        mode3;
	} sfg_cmd_t;
endpackage : sfg_pkg

/* File: sfg_gate.sv */
`timescale 1ns/1ps
// Behaviour
// - decode page, byte/buffer, dummy field layout
// - data output tri-stated after power-up, reset
// - first command only after chip-select falling edge
// - idle clock at select fall picks mode
// - commands ignored during power-on reset
// - standby and ready after initialization
// - program/erase held off up to 3 ms
module sfg_gate #(
	parameter int STARTUP_CYC = sfg_pkg::STARTUP_CYCLES
) (
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// spi pins
	input  wire logic              chip_select_n,
	input  wire logic              sck,
	input  wire logic              si,
	output logic                   so,
	output logic                   so_oe,
	// power-on reset from analog
	input  wire logic              por_active,
	// decoded command and status
	output sfg_pkg::sfg_cmd_t      cmd,
	output logic                   standby,
	output logic                   prog_erase_ok
);
	import sfg_pkg::*;

	// two-stage synchronisers, first stage read only by the second
	logic [3:0] s1_q, s2_q;
	logic       cs_prev_q, sck_prev_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s1_q       <= 4'hf;
			s2_q       <= 4'hf;
			cs_prev_q  <= 1'b1;
			sck_prev_q <= 1'b1; // matches synced reset level, no false edge
		end else begin
			s1_q       <= {chip_select_n, sck, si, por_active};
			s2_q       <= s1_q;
			cs_prev_q  <= s2_q[3];
			sck_prev_q <= s2_q[2];
		end
	end
	logic cs_n, sck_s, si_s, por_s, cs_fall, cs_rise, sck_rise;
	assign cs_n     = s2_q[3];
	assign sck_s    = s2_q[2];
	assign si_s     = s2_q[1];
	assign por_s    = s2_q[0];
	assign cs_fall  = cs_prev_q & ~cs_n;
	assign cs_rise  = ~cs_prev_q & cs_n;
	assign sck_rise = ~sck_prev_q & sck_s;

	function automatic logic [2:0] dummy_of(input logic [7:0] op);
		case (op)
			OP_MAIN_READ: dummy_of = DUMMY_MAIN;
			OP_BUF1_READ, OP_BUF2_READ: dummy_of = DUMMY_BUF;
			default: dummy_of = 3'h0;
		endcase
	endfunction

	// startup counter: program/erase wait after power-up
	logic [31:0] pu_cnt_q, pu_cnt_d;
	logic        pe_ok_q, pe_ok_d, stby_q, stby_d;
	always_comb begin
		pu_cnt_d = pu_cnt_q;
		pe_ok_d  = pe_ok_q;
		stby_d   = ~por_s;
		if (por_s) begin
			pu_cnt_d = 32'h0;
			pe_ok_d  = 1'b0;
		end else if (!pe_ok_q) begin
			if (pu_cnt_q >= 32'(STARTUP_CYC - 1))
				pe_ok_d = 1'b1;
			else
				pu_cnt_d = pu_cnt_q + 32'h1;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pu_cnt_q <= 32'h0;
			pe_ok_q  <= 1'b0;
			stby_q   <= 1'b0;
		end else begin
			pu_cnt_q <= pu_cnt_d;
			pe_ok_q  <= pe_ok_d;
			stby_q   <= stby_d;
		end
	end

	// command shifter
	sfg_state_t  st_q, st_d;
	logic [4:0]  bit_q, bit_d;
	logic [7:0]  op_q, op_d;
	logic [23:0] addr_q, addr_d;
	logic [2:0]  dum_q, dum_d;
	logic        mode3_q, mode3_d;
	sfg_cmd_t    cmd_q, cmd_d;
	always_comb begin
		st_d    = st_q;
		bit_d   = bit_q;
		op_d    = op_q;
		addr_d  = addr_q;
		dum_d   = dum_q;
		mode3_d = mode3_q;
		cmd_d   = cmd_q;
		cmd_d.valid = 1'b0;
		if (por_s || cs_rise) begin
			st_d = SFG_IDLE;
		end else if (cs_fall) begin
			// only a fresh select edge opens a command
			st_d    = SFG_OPCODE;
			bit_d   = 5'h0;
			mode3_d = sck_s;
		end else if (sck_rise) begin
			case (st_q)
				SFG_OPCODE: begin
					op_d  = {op_q[6:0], si_s};
					bit_d = bit_q + 5'h1;
					if (bit_q == 5'h7) begin
						st_d  = SFG_ADDR;
						bit_d = 5'h0;
					end
				end
				SFG_ADDR: begin
					addr_d = {addr_q[22:0], si_s};
					bit_d  = bit_q + 5'h1;
					if (bit_q == 5'h17) begin
						bit_d = 5'h0;
						dum_d = dummy_of(op_q);
						st_d  = (dummy_of(op_q) == 3'h0) ? SFG_DONE : SFG_DUMMY;
					end
				end
				SFG_DUMMY: begin
					bit_d = bit_q + 5'h1;
					if (bit_q == 5'h7) begin
						bit_d = 5'h0;
						dum_d = dum_q - 3'h1;
						if (dum_q == 3'h1)
							st_d = SFG_DONE;
					end
				end
				default: ;
			endcase
		end
		if (st_q == SFG_DONE && !por_s && !cs_rise) begin
			// reported once; further clocks are data phase, not ours
			cmd_d.valid     = 1'b1;
			cmd_d.opcode    = op_q;
			cmd_d.page      = addr_q[PAGE_MSB:PAGE_LSB];
			cmd_d.byte_addr = addr_q[BYTE_MSB:0];
			cmd_d.page_used = (op_q == OP_MAIN_READ);
			cmd_d.byte_used = (dummy_of(op_q) != 3'h0);
			cmd_d.dummy     = dummy_of(op_q);
			cmd_d.mode3     = mode3_q;
			st_d            = SFG_IDLE;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st_q    <= SFG_IDLE;
			bit_q   <= 5'h0;
			op_q    <= 8'h00;
			addr_q  <= 24'h0;
			dum_q   <= 3'h0;
			mode3_q <= 1'b0;
			cmd_q   <= '{valid: 1'b0, opcode: 8'h00, page: PAGE_RST, page_used: 1'b0,
				byte_addr: BYTE_RST, byte_used: 1'b0, dummy: 3'h0, mode3: 1'b0};
		end else begin
			st_q    <= st_d;
			bit_q   <= bit_d;
			op_q    <= op_d;
			addr_q  <= addr_d;
			dum_q   <= dum_d;
			mode3_q <= mode3_d;
			cmd_q   <= cmd_d;
		end
	end

	// output stays released: no command here drives data
	logic so_q, so_oe_q;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			so_q    <= 1'b0;
			so_oe_q <= 1'b0;
		end else begin
			so_q    <= 1'b0;
			so_oe_q <= 1'b0;
		end
	end

	assign so            = so_q;
	assign so_oe         = so_oe_q;
	assign cmd           = cmd_q;
	assign standby       = stby_q;
	assign prog_erase_ok = pe_ok_q;

	a_por_ignores: assert property (@(posedge clk_sys) disable iff (rst)
		por_s |=> !cmd_q.valid) else $error("command seen under power-on reset");
	a_mode_sample: assert property (@(posedge clk_sys) disable iff (rst)
		cs_fall && !por_s |=> mode3_q == $past(sck_s)) else $error("mode not sampled");
	a_so_hiz: assert property (@(posedge clk_sys) disable iff (rst)
		!so_oe) else $error("data output driven");
	a_pe_hold: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(pe_ok_q) |-> !$past(por_s) && pu_cnt_q == 32'(STARTUP_CYC - 1))
		else $error("early program enable");
	a_standby_por: assert property (@(posedge clk_sys) disable iff (rst)
		!por_s |=> standby) else $error("standby missing");
	a_need_fall: assert property (@(posedge clk_sys) disable iff (rst)
		st_q == SFG_IDLE && !cs_fall |=> st_q != SFG_OPCODE) else $error("no select edge");
	a_dummy_main: assert property (@(posedge clk_sys) disable iff (rst)
		cmd_q.valid && cmd_q.opcode == OP_MAIN_READ |-> cmd_q.dummy == 3'h4)
		else $error("main read dummy count");
	a_dummy_buf: assert property (@(posedge clk_sys) disable iff (rst)
		cmd_q.valid && cmd_q.opcode == OP_BUF1_READ |-> cmd_q.dummy == 3'h1 && !cmd_q.page_used)
		else $error("buffer read layout");
endmodule : sfg_gate

/* File: sfg_host.sv */
`timescale 1ns/1ps
module sfg_host (
	// clock
	input  wire logic clk_sys,
	// spi pins
	output logic      chip_select_n,
	output logic      sck,
	output logic      si
);
	initial begin
		chip_select_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// eight clk per sck period keeps the device's sampler comfortable
	task automatic send(input logic [7:0] op, input logic [23:0] ad, input int nd,
		input logic m3);
		logic [63:0] sh;
		sh = {op, ad, 32'h0};
		@(posedge clk_sys) sck <= m3; // idle level picks the mode
		repeat (8) @(posedge clk_sys);
		chip_select_n <= 1'b0; // fresh falling edge starts each command
		repeat (8) @(posedge clk_sys);
		for (int i = 0; i < 32 + 8 * nd; i++) begin // msb first, dummies zero
			sck <= 1'b0;
			si <= sh[63 - i];
			repeat (4) @(posedge clk_sys);
			sck <= 1'b1;
			repeat (4) @(posedge clk_sys);
		end
		sck <= m3;
	endtask : send
	task automatic stop;
		chip_select_n <= 1'b1; // released between commands
		si <= ~si; // toggled after release, never a stale level
	endtask : stop
	// clocks with select high must not open a command
	task automatic idle_clocks(input int n);
		for (int i = 0; i < n; i++) begin
			sck <= ~sck;
			si <= ~si;
			repeat (4) @(posedge clk_sys);
		end
	endtask : idle_clocks
endmodule : sfg_host

/* File: sfg_bench.sv */
`timescale 1ns/1ps
module serial_flash_cmd_powerup_gate_bench;
	import sfg_pkg::*;
	localparam int PE_WAIT = 20;
	logic     clk_sys, rst, por_active, chip_select_n, sck, si;
	logic     so, so_oe, standby, prog_erase_ok;
	sfg_cmd_t cmd, got;
	int       n_errors, n_checks;
	int       n_valid = 0;
	// short startup count keeps the run brief
	sfg_gate #(.STARTUP_CYC(PE_WAIT)) sfg_gate_inst (.clk_sys(clk_sys), .rst(rst),
		.chip_select_n(chip_select_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe),
		.por_active(por_active), .cmd(cmd), .standby(standby),
		.prog_erase_ok(prog_erase_ok));
	sfg_host sfg_host_inst (.clk_sys(clk_sys), .chip_select_n(chip_select_n), .sck(sck),
		.si(si));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (cmd.valid === 1'b1) begin
		got <= cmd;
		n_valid <= n_valid + 1;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_valid(input int n0);
		for (int i = 0; i < 400 && n_valid == n0; i++) @(posedge clk_sys);
	endtask : wait_valid
	task automatic t_powerup;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		check(so_oe, 1'b0);
		check(so, 1'b0);
		check(standby, 1'b0);
		por_active <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check(standby, 1'b1);
		check(prog_erase_ok, 1'b0);
		// two sync stages and the count register lag the release by three edges
		repeat (PE_WAIT - 6) @(posedge clk_sys);
		check(prog_erase_ok, 1'b0);
		@(posedge clk_sys);
		check(prog_erase_ok, 1'b1);
	endtask : t_powerup
	task automatic t_layout;
		logic [7:0]  ops [4];
		logic [23:0] ad;
		logic        pu, bu;
		logic [2:0]  nd;
		int          n0;
		// last opcode has no trailing layout, plain address bits only
		ops = '{OP_MAIN_READ, OP_BUF1_READ, OP_BUF2_READ, 8'h53};
		repeat (SEL_CYCLES) @(posedge clk_sys); // first read well after supply up
		for (int k = 0; k < 8; k++) begin
			n0 = n_valid;
			ad = 24'he01234 ^ 24'(k * 24'h0a5201);
			pu = (ops[k % 4] == OP_MAIN_READ);
			bu = (k % 4 != 3);
			nd = pu ? DUMMY_MAIN : (bu ? DUMMY_BUF : 3'h0);
			sfg_host_inst.send(ops[k % 4], ad, int'(nd), k[2]);
			wait_valid(n0);
			check(n_valid, n0 + 1);
			check(got.opcode, ops[k % 4]);
			check(got.page_used, pu);
			if (pu) check(got.page, ad[20:9]);
			check(got.byte_used, bu);
			check(got.byte_addr, ad[8:0]);
			check(got.dummy, nd);
			check(got.mode3, k[2]);
			check(so_oe, 1'b0);
			sfg_host_inst.stop;
			repeat (8) @(posedge clk_sys);
		end
	endtask : t_layout
	task automatic t_no_select;
		int n0;
		n0 = n_valid;
		sfg_host_inst.idle_clocks(96);
		repeat (8) @(posedge clk_sys);
		check(n_valid, n0);
	endtask : t_no_select
	task automatic t_por_block;
		int n0;
		n0 = n_valid;
		por_active <= 1'b1;
		repeat (6) @(posedge clk_sys);
		check(standby, 1'b0);
		sfg_host_inst.send(OP_MAIN_READ, 24'h000200, 4, 1'b0);
		repeat (20) @(posedge clk_sys);
		check(n_valid, n0);
		sfg_host_inst.stop;
		por_active <= 1'b0;
		repeat (8) @(posedge clk_sys);
		check(standby, 1'b1);
		check(prog_erase_ok, 1'b0);
	endtask : t_por_block
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up
	initial begin
		rst = 1'b1;
		por_active = 1'b1;
		n_errors = 0;
		n_checks = 0;
		t_powerup;
		t_layout;
		t_no_select;
		t_por_block;
		wrap_up;
	end
	// run is about 18000 cycles, mostly the select delay; allow 50000
	initial begin
		#250000;
		n_errors++;
		wrap_up;
	end
endmodule : serial_flash_cmd_powerup_gate_bench
